// [shared/dds_port_defines.svh]
// Constants for the synthesizer programming port host
`ifndef DDS_PORT_DEFINES_SVH
`define DDS_PORT_DEFINES_SVH
`define DDS_INSTR_RD_BIT 7
`define DDS_ADDR_W       5
`define DDS_CONTROL_FUNCTION_REG_ONE_ADDR    5'h00
`define DDS_ORDER_BYTE   4'h2
`define DDS_ORDER_BIT    7
`define DDS_HALF_CYC     4
`define DDS_MAX_BYTES    8
`define DDS_PAR_CYCLES   2'h3
`define DDS_BYTE_LAST    3'h7
`endif

// [shared/dds_port_pkg.sv]
// Types for the synthesizer programming port host
`include "dds_port_defines.svh"
package dds_port_pkg;
  typedef struct packed {
    logic        read;       // 1 = read access
    logic        parallel;   // 1 = parallel port, 0 = serial port
    logic [7:0]  addr;       // Serial register address (low 5 bits) or parallel byte address
    logic [3:0]  nBytes;     // Serial register width in bytes, 1..8
    logic [63:0] wdata;      // Write data, byte 0 in bits 7:0
    logic [2:0]  profile;    // Profile select pin value
  } cmd_s;
  typedef enum logic [1:0] {IDLE, SER, PAR} state_e;
endpackage

// [hw/dds_port_host.sv]
// Host controller driving the synthesizer serial and parallel programming pins
`timescale 1ns/100ps
`include "dds_port_defines.svh"
module dds_port_host #(
  parameter int HALF_CYC = `DDS_HALF_CYC        // System clocks per link clock half period
) (
  input  wire logic               clk,          // System clock
  input  wire logic               rst,          // Synchronous reset, high
  input  wire logic               cmdValid,     // Start a transfer
  output logic                    cmdReady,     // Idle, command can be taken
  input  wire dds_port_pkg::cmd_s cmd,          // Transfer description
  input  wire logic               lsbFirstInit, // Bit order the device holds now
  input  wire logic               keepCsLow,    // Hold serial chip select low between cycles
  input  wire logic               suspend,      // Pause a serial cycle with chip select high
  output logic                    done,         // Transfer finished, one cycle
  output logic [63:0]             readData,     // Collected read bytes
  output logic                    lsbFirst,     // Bit order currently in force
  output logic                    csN,          // Chip select, low active
  output logic                    sclk,         // Serial clock
  output logic                    sdioOut,      // Serial data out
  output logic                    sdioOe,       // Serial data drive enable
  input  wire logic               sdioIn,       // Serial data pin level
  output logic                    pclk,         // Parallel clock
  output logic                    rdWr,         // Parallel direction, high = read
  output logic [7:0]              adOut,        // Parallel address/data out
  output logic                    adOe,         // Parallel bus drive enable
  input  wire logic [7:0]         adIn,         // Parallel bus pin levels
  output logic [2:0]              profileSel    // Profile select pins
);
  import dds_port_pkg::*;

  // ----------------------------------------------------------------
  // State and link clock divider
  // ----------------------------------------------------------------
  state_e      state;
  cmd_s        cur;
  logic [7:0]  divCnt;
  logic        lnk;
  logic        hold;
  logic        tick;
  logic        rise;
  logic        fall;
  logic [2:0]  bitIdx;
  logic [3:0]  byteNum;
  logic [7:0]  curByte;
  logic [7:0]  rdByte;
  logic        startLsb;
  logic [1:0]  pRise;
  logic        sdioMeta, sdioSync;
  logic [7:0]  adMeta, adSync;
  logic        lastBit;
  logic [3:0]  dataIdx;
  logic [3:0]  nextIdx;

  // Pausing only with the clock low keeps the device from seeing a short pulse
  assign hold = (state == SER) && suspend && !lnk;
  assign tick = (state != IDLE) && !hold && (divCnt == 8'(HALF_CYC - 1));
  assign rise = tick && !lnk;
  assign fall = tick && lnk;
  assign cmdReady = (state == IDLE);

  // Divider counts only while a transfer runs, so the link clock idles low
  always_ff @(posedge clk) begin
    if (rst || state == IDLE || hold) begin
      divCnt <= 8'h00;
    end else if (tick) begin
      divCnt <= 8'h00;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end

  // Link clock level
  always_ff @(posedge clk) begin
    if (rst || state == IDLE) begin
      lnk <= 1'b0;
    end else if (tick) begin
      lnk <= !lnk;
    end
  end

  assign sclk = (state == SER) && lnk;
  assign pclk = (state == PAR) && lnk;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  // Device answers come from outside this clock, two flops before use
  always_ff @(posedge clk) begin
    if (rst) begin
      sdioMeta <= 1'b0;
      sdioSync <= 1'b0;
      adMeta   <= 8'h00;
      adSync   <= 8'h00;
    end else begin
      sdioMeta <= sdioIn;
      sdioSync <= sdioMeta;
      adMeta   <= adIn;
      adSync   <= adMeta;
    end
  end

  // ----------------------------------------------------------------
  // Serial sequencing
  // ----------------------------------------------------------------
  assign lastBit = (bitIdx == `DDS_BYTE_LAST);
  // Byte order is fixed by the order in force at cycle start
  assign nextIdx = startLsb ? byteNum : cur.nBytes - byteNum - 4'h1;
  assign dataIdx = startLsb ? byteNum - 4'h1 : cur.nBytes - byteNum;

  // Transfer state machine
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= IDLE;
      cur   <= '0;
    end else begin
      case (state)
        IDLE: begin
          if (cmdValid) begin
            cur   <= cmd;
            state <= cmd.parallel ? PAR : SER;
          end
        end
        SER: begin
          if (fall && lastBit && byteNum == cur.nBytes) begin
            state <= IDLE;
          end
        end
        PAR: begin
          if (fall && pRise == `DDS_PAR_CYCLES) begin
            state <= IDLE;
          end
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end

  // Bit and byte counters, outgoing byte and bit order
  always_ff @(posedge clk) begin
    if (rst) begin
      bitIdx   <= 3'h0;
      byteNum  <= 4'h0;
      curByte  <= 8'h00;
      startLsb <= 1'b0;
      lsbFirst <= 1'b0;
    end else if (state == IDLE) begin
      bitIdx  <= 3'h0;
      byteNum <= 4'h0;
      if (cmdValid) begin
        lsbFirst <= lsbFirstInit;
        startLsb <= lsbFirstInit;
        // Don't-care bits sent as zero; low five bits pick the register
        curByte  <= {cmd.read, 2'b00, cmd.addr[`DDS_ADDR_W-1:0]};
      end
    end else if (state == SER && fall) begin
      if (lastBit) begin
        // Writing the order bit switches bit order for the rest of the cycle
        if (!cur.read && cur.addr[`DDS_ADDR_W-1:0] == `DDS_CONTROL_FUNCTION_REG_ONE_ADDR && byteNum != 4'h0
            && dataIdx == `DDS_ORDER_BYTE) begin
          lsbFirst <= curByte[`DDS_ORDER_BIT];
        end
        bitIdx  <= 3'h0;
        byteNum <= byteNum + 4'h1;
        curByte <= cur.wdata[{nextIdx[2:0], 3'h0} +: 8];
      end else begin
        bitIdx <= bitIdx + 3'h1;
      end
    end
  end

  // Host changes data with the clock low; the device samples on the rise
  // A flop keeps mux glitches off the pin; one clock of lag is far inside the low phase
  always_ff @(posedge clk) begin
    if (rst) begin
      sdioOut <= 1'b0;
    end else begin
      sdioOut <= lsbFirst ? curByte[bitIdx] : curByte[3'h7 - bitIdx];
    end
  end
  assign sdioOe  = (state == SER) && !hold && (byteNum == 4'h0 || !cur.read);

  // Read bits are taken just before the rise, when device data has settled
  always_ff @(posedge clk) begin
    if (rst) begin
      rdByte <= 8'h00;
    end else if (state == SER && rise && byteNum != 4'h0) begin
      if (lsbFirst) begin
        rdByte[bitIdx] <= sdioSync;
      end else begin
        rdByte[3'h7 - bitIdx] <= sdioSync;
      end
    end
  end

  // ----------------------------------------------------------------
  // Parallel sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || state != PAR) begin
      pRise <= 2'h0;
    end else if (rise) begin
      pRise <= pRise + 2'h1;
    end
  end

  assign rdWr = (state == PAR) && cur.read;

  // Address in the first cycle, then write data or a released bus
  always_ff @(posedge clk) begin
    if (rst) begin
      adOut <= 8'h00;
      adOe  <= 1'b0;
    end else if (state == IDLE) begin
      adOut <= cmd.addr;
      adOe  <= cmdValid && cmd.parallel;
    end else if (state == PAR && fall) begin
      if (pRise == 2'h1) begin
        adOut <= cur.wdata[7:0];
        adOe  <= !cur.read;
      end else if (pRise == `DDS_PAR_CYCLES) begin
        adOe  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Chip select, profile pins, results
  // ----------------------------------------------------------------
  always_comb begin
    case (state)
      SER:     csN = hold;
      PAR:     csN = 1'b0;
      IDLE:    csN = !keepCsLow;
      default: csN = 1'b1;
    endcase
  end

  // Profile pins settle before the clock starts
  always_ff @(posedge clk) begin
    if (rst) begin
      profileSel <= 3'h0;
    end else if (state == IDLE && cmdValid) begin
      profileSel <= cmd.profile;
    end
  end

  // Read bytes land in their register position; done marks the end
  always_ff @(posedge clk) begin
    if (rst) begin
      readData <= 64'h0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (state == IDLE && cmdValid) begin
        readData <= 64'h0;
      end
      if (state == SER && fall && lastBit && byteNum != 4'h0 && cur.read) begin
        readData[{dataIdx[2:0], 3'h0} +: 8] <= rdByte;
      end
      if (state == PAR && rise && pRise == 2'h2 && cur.read) begin
        readData[7:0] <= adSync;
      end
      if (fall && ((state == SER && lastBit && byteNum == cur.nBytes) ||
                   (state == PAR && pRise == `DDS_PAR_CYCLES))) begin
        done <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_instr_drive: assert property (state == SER && byteNum == 4'h0 && bitIdx == 3'h0 && !lsbFirst && rise
                                  |-> sdioOe && sdioOut == cur.read)
    else $error("instruction byte not driven");
  a_read_release: assert property (state == SER && byteNum != 4'h0 && cur.read |-> !sdioOe)
    else $error("host drives data pin in read phase");
  a_idle_cs: assert property (state == IDLE && !keepCsLow |-> csN)
    else $error("chip select low while idle");
  a_par_release: assert property (state == PAR && cur.read && pRise >= 2'h2 |-> !adOe)
    else $error("bus not released in parallel read");
  a_par_length: assert property (done && $past(state) == PAR |-> $past(pRise) == 2'h3)
    else $error("parallel access not three cycles");
  a_ser_length: assert property (state == SER && fall && lastBit && byteNum == cur.nBytes
                                 |=> done && state == IDLE)
    else $error("serial cycle did not end after last byte");
  a_data_stable: assert property ($rose(sclk) && sdioOe |-> $stable(sdioOut))
    else $error("serial data changed at rising clock");
  a_suspend_cs: assert property (state == SER && hold |-> csN && !sclk ##1 (suspend || !csN))
    else $error("suspend did not hold chip select high");
  a_profile_set: assert property (state != IDLE |-> profileSel == cur.profile)
    else $error("profile pins changed during transfer");
endmodule

// [verif/dds_device_model.sv]
// Behavioural model of the synthesizer serial and parallel programming ports
`timescale 1ns/100ps
module dds_device_model (
  input  wire logic       clk,     // Bench clock
  input  wire logic       csN,     // Chip select, low active
  input  wire logic       sclk,    // Serial clock
  input  wire logic       sdioOut, // Host serial data
  input  wire logic       sdioOe,  // Host serial drive
  output logic            sdioIn,  // Resolved serial line
  input  wire logic       pclk,    // Parallel clock
  input  wire logic       rdWr,    // Parallel direction
  input  wire logic [7:0] adOut,   // Host bus data
  input  wire logic       adOe,    // Host bus drive
  output logic [7:0]      adIn,    // Resolved bus
  output logic            clash    // Both ends drove one line
);
  logic [63:0] regs [32];
  logic [7:0]  pmem [256];
  logic [7:0]  instr = 8'h00;
  logic [7:0]  sh = 8'h00;
  logic [7:0]  pa = 8'h00;
  logic [7:0]  pd = 8'h00;
  logic [6:0]  bitCnt = 7'h00;
  logic [3:0]  nb = 4'h4;
  logic [3:0]  bi = 4'h0;
  logic [1:0]  pc = 2'h0;
  logic        lsb = 1'b0;
  logic        rd = 1'b0;
  logic        up = 1'b0;
  logic        pr = 1'b0;
  logic        devOe = 1'b0;
  logic        devOut = 1'b0;
  logic        pOe = 1'b0;

  // Register widths in bytes; unknown addresses act as six-byte profiles
  function automatic logic [3:0] width(input logic [4:0] a);
    return (a == 5'h01 || a == 5'h04) ? 4'h2 : (a > 5'h04) ? 4'h6 : 4'h4;
  endfunction

  initial begin
    clash = 1'b0;
    for (int i = 0; i < 32; i++) regs[i] = 64'h0123_4567_89ab_cdef ^ 64'(i);
    for (int i = 0; i < 256; i++) pmem[i] = 8'(i) ^ 8'h5a;
  end

  // Released lines toggle each cycle so a stale sample cannot pass by luck
  assign sdioIn = sdioOe ? sdioOut : (devOe && !csN) ? devOut : clk;
  assign adIn = adOe ? adOut : pOe ? pd : {8{clk}};

  always @(posedge clk) begin
    if ((sdioOe && devOe && !csN) || (adOe && pOe)) clash <= 1'b1;
  end

  // Rising edge: sample host bits; chip select high freezes the cycle
  always @(posedge sclk) begin
    if (!csN) begin
      if (bitCnt < 7'h08) begin
        instr = lsb ? {sdioIn, instr[7:1]} : {instr[6:0], sdioIn};
        if (bitCnt == 7'h07) begin
          rd = instr[7];
          nb = width(instr[4:0]);
          up = lsb;
          bi = lsb ? 4'h0 : nb - 4'h1;
        end
      end else begin
        if (!rd) sh = lsb ? {sdioIn, sh[7:1]} : {sh[6:0], sdioIn};
        if (bitCnt[2:0] == 3'h7) begin
          if (!rd) regs[instr[4:0]][{bi[2:0], 3'h0} +: 8] = sh;
          if (!rd && instr[4:0] == 5'h00 && bi == 4'h2) lsb = sh[7];
          bi = up ? bi + 4'h1 : bi - 4'h1;
        end
      end
      bitCnt = (bitCnt == {nb, 3'h7}) ? 7'h00 : bitCnt + 7'h01;
    end
  end

  // Falling edge: read data goes out only in the data phase
  always @(negedge sclk) begin
    devOe = !csN && rd && bitCnt >= 7'h08;
    devOut = regs[instr[4:0]][{bi[2:0], lsb ? bitCnt[2:0] : ~bitCnt[2:0]}];
  end

  // Parallel access: address, data, re-initialization; chip select high aborts
  always @(posedge pclk or posedge csN) begin
    if (csN) begin
      pc = 2'h0;
      pOe = 1'b0;
    end else begin
      pc = pc + 2'h1;
      if (pc == 2'h1) begin
        pa = adIn;
        pr = rdWr;
      end else if (pc == 2'h2) begin
        if (pr) pd = pmem[pa];
        else pmem[pa] = adIn;
        pOe = pr;
      end
    end
  end

  // Read data is held past the third rise, then the bus is let go
  always @(negedge pclk) begin
    if (pc == 2'h3) begin
      pc = 2'h0;
      pOe = 1'b0;
    end
  end
endmodule

// [verif/dds_port_host_test.sv]
// Self-checking bench for the synthesizer programming port host
`timescale 1ns/100ps
module dds_port_host_test;
  import dds_port_pkg::*;
  `define CHECK(what, want, seen) begin comparisons++; if ((seen) !== (want)) begin fails++; \
    $display("wrong value %s expected %h seen %h", what, want, seen); end end
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmdValid = 1'b0;
  logic        lsbFirstInit = 1'b0;
  logic        keepCsLow = 1'b0;
  logic        suspend = 1'b0;
  cmd_s        cmd = '0;
  logic        cmdReady, done, lsbFirst, csN, sclk, sdioOut, sdioOe, sdioIn, pclk, rdWr, adOe, clash;
  logic [63:0] readData;
  logic [7:0]  adOut, adIn;
  logic [2:0]  profileSel;
  int          fails = 0;
  int          comparisons = 0;

  dds_port_host u_dds_port_host (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
    .lsbFirstInit(lsbFirstInit), .keepCsLow(keepCsLow), .suspend(suspend), .done(done), .readData(readData),
    .lsbFirst(lsbFirst), .csN(csN), .sclk(sclk), .sdioOut(sdioOut), .sdioOe(sdioOe), .sdioIn(sdioIn),
    .pclk(pclk), .rdWr(rdWr), .adOut(adOut), .adOe(adOe), .adIn(adIn), .profileSel(profileSel));
  dds_device_model u_dds_device_model (.clk(clk), .csN(csN), .sclk(sclk), .sdioOut(sdioOut), .sdioOe(sdioOe),
    .sdioIn(sdioIn), .pclk(pclk), .rdWr(rdWr), .adOut(adOut), .adOe(adOe), .adIn(adIn), .clash(clash));

  initial forever #10 clk = ~clk;

  task automatic complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One command through the user port, then a bounded wait for done
  task automatic xfer(input logic rd, par, input logic [7:0] a, input logic [3:0] n, input logic [63:0] wd,
                      output int cyc);
    @(posedge clk);
    cmd <= '{read: rd, parallel: par, addr: a, nBytes: n, wdata: wd, profile: a[2:0]};
    cmdValid <= 1'b1;
    @(posedge clk);
    cmdValid <= 1'b0;
    @(negedge clk);
    `CHECK("profileSel", a[2:0], profileSel)
    `CHECK("cmdReady busy", 1'b0, cmdReady)
    cyc = 1;
    while (done !== 1'b1 && cyc < 3000) begin
      @(negedge clk);
      cyc++;
    end
    // A missing done counts as a mismatch and the run still reaches the verdict
    `CHECK("done", 1'b1, done)
  endtask

  // Whole-register serial access; one link period is eight clocks
  task automatic ser(input logic rd, input logic [7:0] a, input logic [63:0] wd);
    int cyc;
    logic [3:0] n;
    n = (a[4:0] == 5'h01 || a[4:0] == 5'h04) ? 4'h2 : (a[4:0] > 5'h04) ? 4'h6 : 4'h4;
    xfer(rd, 1'b0, a, n, wd, cyc);
    `CHECK("serial length", 1'b1, cyc >= 64 * (n + 1) - 8 && cyc <= 64 * (n + 1) + 16)
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [63:0] want);
    ser(1'b1, {3'h0, a}, 64'h0);
    `CHECK("serial read", want, readData)
  endtask

  task automatic t_serial;
    ser(1'b0, 8'h01, 64'h0000_0000_0000_a5c3);
    rdchk(5'h01, 64'h0000_0000_0000_a5c3);
    ser(1'b0, 8'he3, 64'h0000_0000_1122_3344);
    rdchk(5'h03, 64'h0000_0000_1122_3344);
    rdchk(5'h09, (64'h0123_4567_89ab_cdef ^ 64'h9) & 64'h0000_ffff_ffff_ffff);
  endtask

  // Bit order flips in the middle of a control register write
  task automatic t_order;
    ser(1'b0, 8'h00, 64'h0000_0000_0080_0011);
    `CHECK("lsbFirst", 1'b1, lsbFirst)
    @(posedge clk);
    lsbFirstInit <= 1'b1;
    rdchk(5'h00, 64'h0000_0000_0080_0011);
    rdchk(5'h03, 64'h0000_0000_1122_3344);
    ser(1'b0, 8'h00, 64'h0);
    `CHECK("lsbFirst", 1'b0, lsbFirst)
    @(posedge clk);
    lsbFirstInit <= 1'b0;
    rdchk(5'h00, 64'h0);
  endtask

  task automatic t_suspend;
    int cyc;
    fork
      xfer(1'b0, 1'b0, 8'h04, 4'h2, 64'h0000_0000_0000_beef, cyc);
      begin
        repeat (100) @(posedge clk);
        suspend <= 1'b1;
        repeat (40) @(negedge clk);
        `CHECK("csN suspended", 1'b1, csN)
        @(posedge clk);
        suspend <= 1'b0;
      end
    join
    rdchk(5'h04, 64'h0000_0000_0000_beef);
  endtask

  task automatic t_keep;
    @(posedge clk);
    keepCsLow <= 1'b1;
    ser(1'b0, 8'h02, 64'h0000_0000_5566_7788);
    repeat (3) @(negedge clk);
    `CHECK("csN held low", 1'b0, csN)
    rdchk(5'h02, 64'h0000_0000_5566_7788);
    @(posedge clk);
    keepCsLow <= 1'b0;
  endtask

  task automatic t_par;
    int cyc;
    xfer(1'b0, 1'b1, 8'h0e, 4'h1, 64'h3c, cyc);
    xfer(1'b1, 1'b1, 8'h0e, 4'h1, 64'h0, cyc);
    `CHECK("parallel read", 8'h3c, readData[7:0])
    `CHECK("parallel length", 1'b1, cyc >= 24 && cyc <= 40)
    xfer(1'b1, 1'b1, 8'h33, 4'h1, 64'h0, cyc);
    `CHECK("parallel default", 8'h33 ^ 8'h5a, readData[7:0])
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_serial;
    t_order;
    t_suspend;
    t_keep;
    t_par;
    `CHECK("line contention", 1'b0, clash)
    complete_run;
  end

  // Watchdog well beyond the roughly four thousand three hundred cycles the tests need
  initial begin
    #800000;
    fails++;
    complete_run;
  end
endmodule
